// [logic/acsd_pkg.sv]
package acsd_pkg;

  // setup pair register map and setup layout
  localparam int unsigned NUM_PAIRS = 4;
  localparam int unsigned PAIR_IDX_W = 2;
  localparam int unsigned SETUP_W = 16;
  localparam int unsigned UPPER_SHIFT = 16;
  localparam logic [31:0] PAIR_RST = 32'h0000_0000;

  // field positions inside one 16-bit setup
  localparam int unsigned CH_LSB = 14;
  localparam int unsigned GAIN_LSB = 11;
  localparam int unsigned RATE_LSB = 7;
  localparam int unsigned POL_BIT = 6;
  localparam int unsigned LATCH_LSB = 4;
  localparam int unsigned DT_BIT = 3;
  localparam int unsigned OCD_BIT = 2;
  localparam int unsigned CALP_LSB = 0;

  // reserved codes
  localparam logic [2:0] GAIN_RSVD = 3'h7;
  localparam logic [3:0] RATE_LO_MAX = 4'h4;
  localparam logic [3:0] RATE_HI_MIN = 4'h8;
  localparam logic [3:0] RATE_HI_MAX = 4'hC;
  localparam int unsigned RATE_BAND_BIT = 3;

  // calibration registers
  localparam logic [31:0] GAIN_RST = 32'h0100_0000;
  localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
  localparam logic [31:0] GAIN_WMASK = 32'h3FFF_FFFF;
  localparam logic [31:0] OFFSET_WMASK = 32'hFFFF_FF00;

  // timing in master clock cycles (clk_i is the master clock)
  localparam int unsigned SETTLE_W = 11;
  localparam logic [10:0] SETTLE_STD = 11'h500;
  localparam logic [10:0] SETTLE_ALT = 11'h600;
  localparam int unsigned PERIOD_W = 20;
  localparam logic [19:0] LO_BASE_STD = 20'h0A000;
  localparam logic [19:0] LO_BASE_ALT = 20'h0C000;
  localparam logic [19:0] HI_BASE_STD = 20'h00500;
  localparam logic [19:0] HI_BASE_ALT = 20'h00600;

  typedef struct packed {
    logic [3:0][31:0] pair;
    logic [3:0][31:0] offset;
    logic [3:0][31:0] gain;
    logic [15:0] act;
    logic [19:0] period;
    logic [1:0] cal_sel;
    logic [31:0] rd_pair;
    logic [31:0] rd_offset;
    logic [31:0] rd_gain;
    logic [31:0] cal_offset;
    logic [31:0] cal_gain;
    logic lat0;
    logic lat1;
    logic cont;
    logic pend_long;
    logic start;
    logic long_flag;
  } acsd_bank_t;

  typedef struct packed {
    logic [10:0] cnt;
  } acsd_timer_t;

endpackage

// [logic/acsd_settle_timer.sv]
`timescale 1ns/1ps
module acsd_settle_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic load_i,
  input wire logic abort_i,
  input wire logic [acsd_pkg::SETTLE_W-1:0] cycles_i,
  // status
  output logic busy_o,
  output logic done_o
);
  import acsd_pkg::*;

  acsd_timer_t st;
  acsd_timer_t next_st;

  always_comb begin
    next_st = st;
    if (abort_i) begin
      next_st.cnt = '0;
    end else if (load_i) begin
      next_st.cnt = cycles_i;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 11'h001;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_o = (st.cnt != '0);
  // comb so that the owner registers start on the last count
  assign done_o = (st.cnt == 11'h001) && !load_i && !abort_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_timer_counts: assert property (
    load_i && !abort_i |=> busy_o && st.cnt == $past(cycles_i))
    else $error("settle timer load wrong");

  a_timer_steps: assert property (
    busy_o && !load_i && !abort_i |=> st.cnt == $past(st.cnt) - 11'h001)
    else $error("settle timer step wrong");

endmodule // acsd_settle_timer

// [logic/acsd_setup_bank.sv]
// Functional notes
// - channel_select picks physical channel one to four
// - gain_code gives gain two to the code
// - rate_code selects nominal continuous word rate
// - rates scale with supplied master clock
// - first continuous and single results take longer
// - polarity_select zero bipolar, one unipolar
// - on command, latch outputs take latch_value
// - settle delay 1280 or 1536 cycles first
// - open_input_detect drives selected channel current source
// - cal_set_pointer used only with cal_source_select
// - pointer codes pick channel one to four calibration
// - reset calibration means gain one, offset zero
// - one offset and gain register per channel
// - offset top bit is the trim sign
// - offset step is fixed fraction of span
// - offset magnitude is scaled by gain register
// - gain register unsigned, bits 29:0 weighted
// - config latch bits drive outputs when selected
`timescale 1ns/1ps
module acsd_setup_bank (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // setup pair register access
  input wire logic setup_wr_i,
  input wire logic [acsd_pkg::PAIR_IDX_W-1:0] setup_idx_i,
  input wire logic [31:0] setup_wdata_i,
  output logic [31:0] setup_rdata_o,
  // calibration register access
  input wire logic offset_wr_i,
  input wire logic gain_wr_i,
  input wire logic [1:0] cal_idx_i,
  input wire logic [31:0] cal_wdata_i,
  output logic [31:0] offset_rdata_o,
  output logic [31:0] gain_rdata_o,
  // configuration bits
  input wire logic rate_family_select_i,
  input wire logic latch_source_select_i,
  input wire logic cal_source_select_i,
  input wire logic [1:0] cfg_latch_i,
  // command execution
  input wire logic exec_i,
  input wire logic [2:0] exec_setup_i,
  input wire logic continuous_i,
  input wire logic conv_next_i,
  input wire logic stop_i,
  // decoded active setup
  output logic [1:0] channel_select_o,
  output logic [2:0] gain_code_o,
  output logic [6:0] gain_factor_o,
  output logic [3:0] rate_code_o,
  output logic [acsd_pkg::PERIOD_W-1:0] period_cycles_o,
  output logic unipolar_o,
  output logic [3:0] open_input_detect_o,
  output logic reserved_code_o,
  // calibration set in use
  output logic [1:0] cal_set_o,
  output logic [31:0] cal_offset_o,
  output logic [31:0] cal_gain_o,
  // latch pins
  output logic latch_out_0_o,
  output logic latch_out_1_o,
  // conversion timing
  output logic conv_start_o,
  output logic conv_long_o,
  output logic settle_busy_o,
  output logic continuous_o
);
  import acsd_pkg::*;

  acsd_bank_t st;
  acsd_bank_t next_st;
  logic [15:0] sel_setup;
  logic [31:0] sel_pair;
  logic sel_dt;
  logic timer_load;
  logic timer_done;
  logic timer_busy;
  logic [SETTLE_W-1:0] settle_cycles;
  logic [3:0] act_rate;
  logic [19:0] base;

  // setup 1 (exec_setup_i 0) is the upper half of pair 0
  always_comb begin
    sel_pair = st.pair[exec_setup_i[2:1]];
    if (exec_setup_i[0]) begin
      sel_setup = sel_pair[SETUP_W-1:0];
    end else begin
      sel_setup = sel_pair[31:UPPER_SHIFT];
    end
  end

  assign sel_dt = sel_setup[DT_BIT];
  assign timer_load = exec_i && sel_dt;
  assign settle_cycles = rate_family_select_i ? SETTLE_ALT
                                              : SETTLE_STD;

  acsd_settle_timer u_settle (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(timer_load),
    .abort_i(stop_i && !timer_load),
    .cycles_i(settle_cycles),
    .busy_o(timer_busy),
    .done_o(timer_done)
  );

  assign act_rate = sel_setup[RATE_LSB +: 4];

  // period in master clock cycles, so it tracks any clock rate
  always_comb begin
    if (act_rate[RATE_BAND_BIT]) begin
      base = rate_family_select_i ? HI_BASE_ALT : HI_BASE_STD;
    end else begin
      base = rate_family_select_i ? LO_BASE_ALT : LO_BASE_STD;
    end
  end

  always_comb begin
    next_st = st;
    next_st.start = 1'b0;
    // register writes, whole pair at once
    if (setup_wr_i) begin
      next_st.pair[setup_idx_i] = setup_wdata_i;
    end
    if (offset_wr_i) begin
      next_st.offset[cal_idx_i] = cal_wdata_i & OFFSET_WMASK;
    end
    if (gain_wr_i) begin
      next_st.gain[cal_idx_i] = cal_wdata_i & GAIN_WMASK;
    end
    next_st.rd_pair = st.pair[setup_idx_i];
    next_st.rd_offset = st.offset[cal_idx_i];
    next_st.rd_gain = st.gain[cal_idx_i];
    // command execution captures the addressed setup
    if (exec_i) begin
      next_st.act = sel_setup;
      next_st.period = base << act_rate[2:0];
      next_st.cont = continuous_i;
      if (sel_dt) begin
        next_st.pend_long = 1'b1;
      end else begin
        next_st.start = 1'b1;
        next_st.long_flag = 1'b1;
        next_st.pend_long = 1'b0;
      end
    end else if (stop_i) begin
      next_st.cont = 1'b0;
      next_st.pend_long = 1'b0;
    end else if (timer_done && st.pend_long) begin
      next_st.start = 1'b1;
      next_st.long_flag = 1'b1;
      next_st.pend_long = 1'b0;
    end else if (conv_next_i && st.cont && !timer_busy && !st.pend_long) begin
      next_st.start = 1'b1;
      next_st.long_flag = 1'b0;
    end
    // latch pins
    if (latch_source_select_i) begin
      next_st.lat0 = cfg_latch_i[1];
      next_st.lat1 = cfg_latch_i[0];
    end else if (exec_i) begin
      next_st.lat0 = sel_setup[LATCH_LSB + 1];
      next_st.lat1 = sel_setup[LATCH_LSB];
    end
    // calibration set follows live source select
    if (cal_source_select_i) begin
      next_st.cal_sel = st.act[CALP_LSB +: 2];
    end else begin
      next_st.cal_sel = st.act[CH_LSB +: 2];
    end
    // offset is applied through the gain downstream
    next_st.cal_offset = st.offset[next_st.cal_sel];
    next_st.cal_gain = st.gain[next_st.cal_sel];
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
      for (int i = 0; i < NUM_PAIRS; i++) begin
        st.pair[i] <= PAIR_RST;
        st.offset[i] <= OFFSET_RST;
        st.gain[i] <= GAIN_RST;
      end
      st.cal_gain <= GAIN_RST;
    end else begin
      st <= next_st;
    end
  end

  assign setup_rdata_o = st.rd_pair;
  assign offset_rdata_o = st.rd_offset;
  assign gain_rdata_o = st.rd_gain;
  assign channel_select_o = st.act[CH_LSB +: 2];
  assign gain_code_o = st.act[GAIN_LSB +: 3];
  assign gain_factor_o = 7'h01 << st.act[GAIN_LSB +: 3];
  assign rate_code_o = st.act[RATE_LSB +: 4];
  assign period_cycles_o = st.period;
  assign unipolar_o = st.act[POL_BIT];
  assign open_input_detect_o = st.act[OCD_BIT]
                               ? (4'h1 << st.act[CH_LSB +: 2])
                               : 4'h0;
  // unused codes are flagged only; no behaviour is promised for them
  assign reserved_code_o = (st.act[GAIN_LSB +: 3] == GAIN_RSVD)
    || (rate_code_o > RATE_LO_MAX && rate_code_o < RATE_HI_MIN)
    || (rate_code_o > RATE_HI_MAX);
  assign cal_set_o = st.cal_sel;
  assign cal_offset_o = st.cal_offset;
  assign cal_gain_o = st.cal_gain;
  assign latch_out_0_o = st.lat0;
  assign latch_out_1_o = st.lat1;
  assign conv_start_o = st.start;
  assign conv_long_o = st.long_flag;
  assign settle_busy_o = timer_busy;
  assign continuous_o = st.cont;

  // helper: cycles from a delayed command to its start
  logic [11:0] hlp_cnt;
  logic [11:0] hlp_exp;
  logic hlp_arm;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hlp_cnt <= '0;
      hlp_exp <= '0;
      hlp_arm <= 1'b0;
    end else if (exec_i) begin
      hlp_cnt <= 12'h001;
      hlp_exp <= {1'b0, settle_cycles} + 12'h001;
      hlp_arm <= sel_dt;
    end else if (stop_i || conv_start_o) begin
      hlp_arm <= 1'b0;
    end else begin
      hlp_cnt <= hlp_cnt + 12'h001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_latch_from_setup: assert property (
    exec_i && !latch_source_select_i |=>
      latch_out_0_o == $past(sel_setup[5]) &&
      latch_out_1_o == $past(sel_setup[4]))
    else $error("latch pins not taken from setup");

  a_latch_from_cfg: assert property (
    latch_source_select_i |=>
      {latch_out_0_o, latch_out_1_o} == $past(cfg_latch_i))
    else $error("latch pins not following config bits");

  a_start_no_delay: assert property (
    exec_i && !sel_dt |=> conv_start_o && conv_long_o)
    else $error("immediate start missing");

  a_start_after_settle: assert property (
    hlp_arm && conv_start_o |-> hlp_cnt == hlp_exp && conv_long_o)
    else $error("settle delay length wrong");

  a_period_std: assert property (
    exec_i && !rate_family_select_i && act_rate == 4'h0 |=>
      period_cycles_o == 20'h0A000)
    else $error("standard period wrong");

  a_period_alt: assert property (
    exec_i && rate_family_select_i && act_rate == 4'hC |=>
      period_cycles_o == 20'h06000)
    else $error("scaled period wrong");

  a_cal_pointer: assert property (
    ##1 cal_set_o == ($past(cal_source_select_i)
      ? $past(st.act[1:0]) : $past(st.act[15:14])))
    else $error("calibration set selection wrong");

  a_open_detect: assert property (
    $onehot0(open_input_detect_o) &&
    (open_input_detect_o != 4'h0) == st.act[OCD_BIT])
    else $error("current source decode wrong");

  a_cont_nominal: assert property (
    conv_next_i && continuous_o && !settle_busy_o && !st.pend_long &&
    !exec_i && !stop_i |=> conv_start_o && !conv_long_o)
    else $error("continuous follow-on start wrong");

  a_gain_fields: assert property (
    gain_rdata_o[31:30] == 2'h0 && offset_rdata_o[7:0] == 8'h00)
    else $error("unused calibration bits not zero");

  a_polarity: assert property (
    exec_i |=> unipolar_o == $past(sel_setup[6]))
    else $error("polarity not captured");

endmodule // acsd_setup_bank

// [verif/acsd_host_model.sv]
`timescale 1ns/1ps
module acsd_host_model (
  // clock
  input wire logic clk_i,
  // register writes toward the bank
  output logic setup_wr_o,
  output logic [1:0] setup_idx_o,
  output logic [31:0] setup_wdata_o,
  output logic offset_wr_o,
  output logic gain_wr_o,
  output logic [1:0] cal_idx_o,
  output logic [31:0] cal_wdata_o
);
  initial begin
    setup_wr_o = 1'b0;
    setup_idx_o = 2'h0;
    setup_wdata_o = 32'h0;
    offset_wr_o = 1'b0;
    gain_wr_o = 1'b0;
    cal_idx_o = 2'h0;
    cal_wdata_o = 32'h0;
  end
  // both setups always go as one word
  task automatic write_pair(input logic [1:0] i, input logic [31:0] d);
    @(negedge clk_i);
    setup_idx_o = i;
    setup_wdata_o = d;
    setup_wr_o = 1'b1;
    @(negedge clk_i);
    setup_wr_o = 1'b0;
    setup_wdata_o = ~d;
  endtask
  // released data shows the inverse, not the last value
  task automatic write_cal(input logic g, input logic [1:0] i,
                           input logic [31:0] d);
    @(negedge clk_i);
    cal_idx_o = i;
    cal_wdata_o = d;
    offset_wr_o = ~g;
    gain_wr_o = g;
    @(negedge clk_i);
    offset_wr_o = 1'b0;
    gain_wr_o = 1'b0;
    cal_wdata_o = ~d;
  endtask
  task automatic point(input logic [1:0] i);
    @(negedge clk_i);
    setup_idx_o = i;
    cal_idx_o = i;
    repeat (2) @(negedge clk_i);
  endtask
endmodule // acsd_host_model

// [verif/tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb;
  import acsd_pkg::*;
  logic clk_i, sys_rst_i, swr, owr, gwr, rate_family_select, latch_source_select, cal_source_select, exec, cont, cnext;
  logic stop, unip, rsvd, lat0, lat1, cstart, clong, contm, sbusy;
  logic [1:0] sidx, cidx, cfgl, ch, calset;
  logic [2:0] esel, gcode;
  logic [3:0] rcode, open_input_detect;
  logic [6:0] gfac;
  logic [19:0] period;
  logic [31:0] swd, cwd, srd, ord, grd, coff, cgain, d;
  logic [31:0] pairs [4];
  logic [31:0] offs [4];
  logic [31:0] gains [4];
  int miscompares, comparisons, n;
  acsd_setup_bank dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .setup_wr_i(swr), .setup_idx_i(sidx), .setup_wdata_i(swd),
    .setup_rdata_o(srd), .offset_wr_i(owr), .gain_wr_i(gwr),
    .cal_idx_i(cidx), .cal_wdata_i(cwd), .offset_rdata_o(ord),
    .gain_rdata_o(grd), .rate_family_select_i(rate_family_select),
    .latch_source_select_i(latch_source_select), .cal_source_select_i(cal_source_select),
    .cfg_latch_i(cfgl), .exec_i(exec), .exec_setup_i(esel),
    .continuous_i(cont), .conv_next_i(cnext), .stop_i(stop),
    .channel_select_o(ch), .gain_code_o(gcode), .gain_factor_o(gfac),
    .rate_code_o(rcode), .period_cycles_o(period), .unipolar_o(unip),
    .open_input_detect_o(open_input_detect), .reserved_code_o(rsvd),
    .cal_set_o(calset), .cal_offset_o(coff), .cal_gain_o(cgain),
    .latch_out_0_o(lat0), .latch_out_1_o(lat1), .conv_start_o(cstart),
    .conv_long_o(clong), .settle_busy_o(sbusy), .continuous_o(contm));
  acsd_host_model host_u (.clk_i(clk_i), .setup_wr_o(swr),
    .setup_idx_o(sidx), .setup_wdata_o(swd), .offset_wr_o(owr),
    .gain_wr_o(gwr), .cal_idx_o(cidx), .cal_wdata_o(cwd));
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // four times master clock over four times the word rate
  function automatic logic [19:0] exp_period(logic [3:0] r, logic f);
    int unsigned q;
    case (r)
      4'h0: q = 480;
      4'h1: q = 240;
      4'h2: q = 120;
      4'h3: q = 60;
      4'h4: q = 30;
      4'h8: q = 15360;
      4'h9: q = 7680;
      4'hA: q = 3840;
      4'hB: q = 1920;
      default: q = 960;
    endcase
    return 20'(19660800 * (f ? 6 : 5) / (q * 5));
  endfunction
  // reserved gain and rate codes are steered away
  function automatic logic [15:0] rand_setup();
    logic [15:0] s;
    s = 16'($urandom);
    if (s[13:11] == 3'h7) s[13:11] = 3'h6;
    if (s[9:7] > 3'h4) s[9:7] = s[9:7] - 3'h4;
    s[3] = 1'b0;
    return s;
  endfunction
  task automatic wait_start();
    n = 1;
    while (cstart !== 1'b1 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic pulse_exec(input logic [2:0] s, input logic c);
    @(negedge clk_i);
    exec = 1'b1;
    esel = s;
    cont = c;
    @(negedge clk_i);
    exec = 1'b0;
  endtask
  task automatic run_exec(input logic [2:0] s, input logic c);
    pulse_exec(s, c);
    wait_start();
  endtask
  task automatic check_setup(input logic [15:0] su);
    logic [1:0] cs;
    cs = cal_source_select ? su[1:0] : su[15:14];
    `CHK(clong, 1'b1);
    `CHK(ch, su[15:14]);
    `CHK(gcode, su[13:11]);
    `CHK(gfac, 7'h01 << su[13:11]);
    `CHK(rcode, su[10:7]);
    `CHK(period, exp_period(su[10:7], rate_family_select));
    `CHK(unip, su[6]);
    `CHK(open_input_detect, su[2] ? 4'h1 << su[15:14] : 4'h0);
    `CHK(rsvd, 1'b0);
    if (!latch_source_select) begin
      `CHK(lat0, su[5]);
      `CHK(lat1, su[4]);
    end
    @(negedge clk_i);
    `CHK(calset, cs);
    `CHK(coff, offs[cs]);
    `CHK(cgain, gains[cs]);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // whole run is near 5k cycles; allow about four times that
  initial begin
    #(20000 * 100);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hE15904E8));
    {rate_family_select, latch_source_select, cal_source_select, exec, cont, cnext, stop, esel, cfgl} = '0;
    sys_rst_i = 1'b1;
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    `CHK(cgain, GAIN_RST);
    for (int i = 0; i < 4; i++) begin
      host_u.point(2'(i));
      `CHK(srd, PAIR_RST);
      `CHK(ord, 32'h0);
      `CHK(grd, 32'h0100_0000);
    end
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      pairs[i] = {rand_setup(), rand_setup()};
      host_u.write_pair(2'(i), pairs[i]);
      d = $urandom;
      host_u.write_cal(1'b0, 2'(i), d);
      offs[i] = d & 32'hFFFF_FF00;
      gains[i] = $urandom_range(32'h2800_0000);
      host_u.write_cal(1'b1, 2'(i), gains[i]);
    end
    for (int i = 0; i < 4; i++) begin
      host_u.point(2'(i));
      `CHK(srd, pairs[i]);
      `CHK(ord, offs[i]);
      `CHK(grd, gains[i]);
    end
    $display("test registers done");
    repeat (24) begin
      rate_family_select = 1'($urandom);
      cal_source_select = 1'($urandom);
      esel = 3'($urandom);
      d = pairs[esel[2:1]];
      run_exec(esel, 1'b0);
      `CHK(n, 1);
      check_setup(esel[0] ? d[15:0] : d[31:16]);
    end
    $display("test decode done");
    for (int f = 0; f < 2; f++) begin
      rate_family_select = 1'(f);
      pairs[0][19] = 1'b1;
      host_u.write_pair(2'h0, pairs[0]);
      run_exec(3'h0, 1'b0);
      `CHK(n, f ? 1537 : 1281);
      check_setup(pairs[0][31:16]);
    end
    pulse_exec(3'h0, 1'b0);
    `CHK(sbusy, 1'b1);
    stop = 1'b1;
    @(negedge clk_i);
    stop = 1'b0;
    `CHK(sbusy, 1'b0);
    wait_start();
    `CHK(n, 2000);
    $display("test settle done");
    latch_source_select = 1'b1;
    for (int k = 0; k < 4; k++) begin
      cfgl = 2'(k);
      repeat (2) @(negedge clk_i);
      `CHK(lat0, cfgl[1]);
      `CHK(lat1, cfgl[0]);
    end
    latch_source_select = 1'b0;
    $display("test latch source done");
    host_u.write_pair(2'h3, {pairs[3][31:16], 16'h3A80});
    run_exec(3'h7, 1'b0);
    `CHK(rsvd, 1'b1);
    `CHK(gcode, 3'h7);
    $display("test reserved done");
    run_exec(3'h2, 1'b1);
    `CHK(contm, 1'b1);
    `CHK(clong, 1'b1);
    @(negedge clk_i);
    cnext = 1'b1;
    @(negedge clk_i);
    cnext = 1'b0;
    wait_start();
    `CHK(n, 1);
    `CHK(clong, 1'b0);
    @(negedge clk_i);
    stop = 1'b1;
    @(negedge clk_i);
    stop = 1'b0;
    @(negedge clk_i);
    `CHK(contm, 1'b0);
    $display("test continuous done");
    tally_and_finish();
  end
endmodule // tb
